// [design/dpsk_phase_shift_mapper.sv]
// Symbol to phase increment mapper with differential and Gray coding
// Contract
// - Coding off maps pi/4 symbols 00,01,10,11 to +45,+135,-135,-45.
// - North American variant maps 00,01,10,11 to +45,+135,-45,-135.
// - Flight telephone variant maps 00,01,10,11 to -135,+135,-45,+45.
// - Each pi/4 shift adds to previous vector phase, giving eight positions.
// - Combined mode Gray-maps the symbol first, then codes it differentially.
// - Aviation 8PSK maps 0..7 to 0,45,135,90,270,315,225,180 degrees.
// - Aviation differential mapping uses all three symbol bits; others use two.
// - Differential output is input plus previous output, modulo two to bits.
// - Differential QPSK maps 00,01,10,11 to 0,90,180,270 degrees.
`timescale 1ns/100ps
module dpsk_phase_shift_mapper (
    input wire logic clk, // 40 MHz symbol clock
    input wire logic rst, // Synchronous reset, active high
    input wire psk_map_pkg::coding_t coding, // Coding selection
    input wire logic sym_valid, // Symbol offered
    output logic sym_ready, // Room in input FIFO
    input wire logic [psk_map_pkg::SYM_W-1:0] sym_data, // Symbol, MSB first
    output logic ph_valid, // Phase word valid
    input wire logic ph_ready, // Accumulator takes word
    output psk_map_pkg::phase_word_t ph_out // Coded symbol, increment, phase
);
    psk_map_pkg::coding_t mode_q;
    psk_map_pkg::phase_word_t ph_q;
    logic ph_valid_q;
    logic [psk_map_pkg::SYM_W-1:0] prev_q;
    logic [psk_map_pkg::PH_W-1:0] acc_q;
    logic fifo_valid;
    logic fifo_ready;
    logic [psk_map_pkg::SYM_W-1:0] fifo_sym;
    logic mode_chg;
    logic take;
    logic [psk_map_pkg::SYM_W-1:0] a_sym;
    logic [psk_map_pkg::PH_W-1:0] inc_d;
    logic [psk_map_pkg::SYM_W-1:0] prev_d;
    logic [psk_map_pkg::PH_W-1:0] acc_d;

    sym_fifo #(
        .W(psk_map_pkg::SYM_W),
        .D(psk_map_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(sym_valid),
        .in_ready(sym_ready),
        .in_data(sym_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_sym)
    );

    // A symbol is not taken in the cycle the coding changes, so it never
    // mixes old state with the new table
    assign mode_chg = (coding != mode_q);
    assign fifo_ready = (!ph_valid_q || ph_ready) && !mode_chg;
    assign take = fifo_valid && fifo_ready;
    assign ph_valid = ph_valid_q;
    assign ph_out = ph_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= psk_map_pkg::CODE_PI4_OFF;
        end else begin
            mode_q <= coding;
        end
    end

    // Only the aviation mode carries three bits; the top bit is dropped otherwise
    always_comb begin
        a_sym = {1'b0, fifo_sym[psk_map_pkg::QPSK_W-1:0]};
        if (mode_q == psk_map_pkg::CODE_8PSK_AVDL) begin
            a_sym = fifo_sym;
        end
    end

    always_comb begin
        inc_d = psk_map_pkg::PH_0;
        case (mode_q)
            psk_map_pkg::CODE_PI4_OFF: begin
                case (a_sym[1:0])
                    2'h0: inc_d = psk_map_pkg::PH_45;
                    2'h1: inc_d = psk_map_pkg::PH_135;
                    2'h2: inc_d = psk_map_pkg::PH_225;
                    default: inc_d = psk_map_pkg::PH_315;
                endcase
            end
            psk_map_pkg::CODE_PI4_NA: begin
                case (a_sym[1:0])
                    2'h0: inc_d = psk_map_pkg::PH_45;
                    2'h1: inc_d = psk_map_pkg::PH_135;
                    2'h2: inc_d = psk_map_pkg::PH_315;
                    default: inc_d = psk_map_pkg::PH_225;
                endcase
            end
            psk_map_pkg::CODE_PI4_FLIGHT: begin
                case (a_sym[1:0])
                    2'h0: inc_d = psk_map_pkg::PH_225;
                    2'h1: inc_d = psk_map_pkg::PH_135;
                    2'h2: inc_d = psk_map_pkg::PH_315;
                    default: inc_d = psk_map_pkg::PH_45;
                endcase
            end
            psk_map_pkg::CODE_QPSK_DIFF: begin
                case (a_sym[1:0])
                    2'h0: inc_d = psk_map_pkg::PH_0;
                    2'h1: inc_d = psk_map_pkg::PH_90;
                    2'h2: inc_d = psk_map_pkg::PH_180;
                    default: inc_d = psk_map_pkg::PH_270;
                endcase
            end
            psk_map_pkg::CODE_8PSK_AVDL: begin
                // Gray stage ahead of the differential sum
                case (a_sym)
                    3'h0: inc_d = psk_map_pkg::PH_0;
                    3'h1: inc_d = psk_map_pkg::PH_45;
                    3'h2: inc_d = psk_map_pkg::PH_135;
                    3'h3: inc_d = psk_map_pkg::PH_90;
                    3'h4: inc_d = psk_map_pkg::PH_270;
                    3'h5: inc_d = psk_map_pkg::PH_315;
                    3'h6: inc_d = psk_map_pkg::PH_225;
                    default: inc_d = psk_map_pkg::PH_180;
                endcase
            end
            default: inc_d = psk_map_pkg::PH_0;
        endcase
    end

    always_comb begin
        prev_d = a_sym;
        case (mode_q)
            psk_map_pkg::CODE_QPSK_DIFF: begin
                // Truncation to two bits gives modulo 4
                prev_d = {1'b0, 2'(a_sym[1:0] + prev_q[1:0])};
            end
            psk_map_pkg::CODE_8PSK_AVDL: begin
                prev_d = 3'(inc_d + prev_q);
            end
            default: prev_d = a_sym;
        endcase
    end

    // Three-bit wrap keeps the vector on the eight-point ring
    assign acc_d = 3'(acc_q + inc_d);

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= psk_map_pkg::ACC_RST;
            prev_q <= psk_map_pkg::PREV_RST;
        end else if (mode_chg) begin
            acc_q <= psk_map_pkg::ACC_RST;
            prev_q <= psk_map_pkg::PREV_RST;
        end else if (take) begin
            acc_q <= acc_d;
            prev_q <= prev_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ph_valid_q <= 1'b0;
        end else if (take) begin
            ph_valid_q <= 1'b1;
        end else if (ph_ready) begin
            ph_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ph_q <= '0;
        end else if (take) begin
            ph_q.sym <= prev_d;
            ph_q.inc <= inc_d;
            ph_q.acc <= acc_d;
        end
    end

    a_pi4_off_map: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_PI4_OFF && fifo_sym[1:0] == 2'h2
        |=> ph_q.inc == psk_map_pkg::PH_225)
        else $error("Coding off: symbol 10 not mapped to -135");

    a_pi4_na_map: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_PI4_NA && fifo_sym[1:0] == 2'h3
        |=> ph_q.inc == psk_map_pkg::PH_225 && ph_valid_q)
        else $error("North American variant: symbol 11 not mapped to -135");

    a_pi4_flight_map: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_PI4_FLIGHT && fifo_sym[1:0] == 2'h0
        |=> ph_q.inc == psk_map_pkg::PH_225)
        else $error("Flight variant: symbol 00 not mapped to -135");

    a_phase_accum_step: assert property (@(posedge clk) disable iff (rst)
        take |=> ph_q.acc == 3'($past(acc_q) + ph_q.inc) && acc_q == ph_q.acc)
        else $error("Accumulated phase is not previous phase plus shift");

    a_pi4_odd_shift: assert property (@(posedge clk) disable iff (rst)
        take && (mode_q == psk_map_pkg::CODE_PI4_OFF || mode_q == psk_map_pkg::CODE_PI4_NA ||
        mode_q == psk_map_pkg::CODE_PI4_FLIGHT) |=> ph_q.inc[0] && ph_q.acc[0] != $past(acc_q[0]))
        else $error("pi/4 shift did not alternate the phase grid");

    a_avdl_gray_diff: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_8PSK_AVDL && fifo_sym == 3'h4
        |=> ph_q.inc == psk_map_pkg::PH_270 && ph_q.sym == 3'($past(prev_q) + psk_map_pkg::PH_270))
        else $error("Aviation mode: Gray then differential result wrong");

    a_avdl_table: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_8PSK_AVDL && fifo_sym == 3'h7
        |=> ph_q.inc == psk_map_pkg::PH_180)
        else $error("Aviation mode: symbol 111 not mapped to 180");

    a_two_bit_modes: assert property (@(posedge clk) disable iff (rst)
        take && mode_q != psk_map_pkg::CODE_8PSK_AVDL |=> ph_q.sym[2] == 1'b0)
        else $error("Third symbol bit leaked into a two-bit mode");

    a_qpsk_diff_sum: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_QPSK_DIFF
        |=> ph_q.sym[1:0] == 2'($past(fifo_sym[1:0]) + $past(prev_q[1:0])))
        else $error("Differential QPSK output is not input plus previous");

    a_qpsk_phase_map: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_QPSK_DIFF && fifo_sym[1:0] == 2'h1
        |=> ph_q.inc == psk_map_pkg::PH_90)
        else $error("Differential QPSK: symbol 01 not mapped to 90");

    a_pi4_off_first: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_PI4_OFF && fifo_sym[1:0] == 2'h0
        |=> ph_q.inc == psk_map_pkg::PH_45)
        else $error("Coding off: symbol 00 not mapped to +45");

    a_pi4_off_second: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_PI4_OFF && fifo_sym[1:0] == 2'h1
        |=> ph_q.inc == psk_map_pkg::PH_135)
        else $error("Coding off: symbol 01 not mapped to +135");

    a_pi4_off_last: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_PI4_OFF && fifo_sym[1:0] == 2'h3
        |=> ph_q.inc == psk_map_pkg::PH_315)
        else $error("Coding off: symbol 11 not mapped to -45");

    a_pi4_na_first: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_PI4_NA && fifo_sym[1:0] == 2'h0
        |=> ph_q.inc == psk_map_pkg::PH_45)
        else $error("North American variant: symbol 00 not mapped to +45");

    a_pi4_na_third: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_PI4_NA && fifo_sym[1:0] == 2'h2
        |=> ph_q.inc == psk_map_pkg::PH_315)
        else $error("North American variant: symbol 10 not mapped to -45");

    a_pi4_flight_second: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_PI4_FLIGHT && fifo_sym[1:0] == 2'h1
        |=> ph_q.inc == psk_map_pkg::PH_135)
        else $error("Flight variant: symbol 01 not mapped to +135");

    a_pi4_flight_last: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_PI4_FLIGHT && fifo_sym[1:0] == 2'h3
        |=> ph_q.inc == psk_map_pkg::PH_45)
        else $error("Flight variant: symbol 11 not mapped to +45");

    // Table held against the plain Gray code, apart from the case list
    a_avdl_gray_code: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_8PSK_AVDL
        |=> ph_q.inc == ($past(fifo_sym) ^ ($past(fifo_sym) >> 1)))
        else $error("Aviation mode: increment is not the Gray code of the symbol");

    a_avdl_table_two: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_8PSK_AVDL && fifo_sym == 3'h2
        |=> ph_q.inc == psk_map_pkg::PH_135)
        else $error("Aviation mode: symbol 010 not mapped to 135");

    a_avdl_diff_sum: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_8PSK_AVDL
        |=> ph_q.sym == 3'($past(prev_q) + ph_q.inc))
        else $error("Aviation mode: output is not Gray value plus previous");

    a_qpsk_inc_even: assert property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_QPSK_DIFF
        |=> ph_q.inc == {$past(fifo_sym[1:0]), 1'b0})
        else $error("Differential QPSK: increment is not a quarter turn step");

    a_reset_state: assert property (@(posedge clk) rst
        |=> acc_q == psk_map_pkg::ACC_RST && prev_q == psk_map_pkg::PREV_RST && !ph_valid_q)
        else $error("Reset did not clear phase state");

    a_mode_clear: assert property (@(posedge clk) disable iff (rst)
        coding != mode_q |-> !take ##1 acc_q == psk_map_pkg::ACC_RST && prev_q == psk_map_pkg::PREV_RST)
        else $error("Coding change did not clear phase state");

    a_out_hold: assert property (@(posedge clk) disable iff (rst)
        ph_valid_q && !ph_ready |=> ph_valid_q && $stable(ph_q))
        else $error("Phase word changed while stalled");

    c_pi4_stream: cover property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_PI4_NA ##1 take);
    c_avdl_symbol: cover property (@(posedge clk) disable iff (rst)
        take && mode_q == psk_map_pkg::CODE_8PSK_AVDL);
    c_fifo_full: cover property (@(posedge clk) disable iff (rst) !sym_ready);
    c_mode_switch: cover property (@(posedge clk) disable iff (rst)
        ph_valid_q ##1 coding != mode_q);
    c_stall_hold: cover property (@(posedge clk) disable iff (rst)
        ph_valid_q && !ph_ready ##1 ph_valid_q && ph_ready);
endmodule

// [design/psk_map_pkg.sv]
// Shared types and constants for the differential phase mapper
package psk_map_pkg;
    localparam int SYM_W = 3;
    localparam int PH_W = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int QPSK_W = 2;

    // Phase codes in units of 45 degrees, modulo one turn
    localparam logic [PH_W-1:0] PH_0 = 3'h0;
    localparam logic [PH_W-1:0] PH_45 = 3'h1;
    localparam logic [PH_W-1:0] PH_90 = 3'h2;
    localparam logic [PH_W-1:0] PH_135 = 3'h3;
    localparam logic [PH_W-1:0] PH_180 = 3'h4;
    localparam logic [PH_W-1:0] PH_225 = 3'h5;
    localparam logic [PH_W-1:0] PH_270 = 3'h6;
    localparam logic [PH_W-1:0] PH_315 = 3'h7;

    localparam logic [PH_W-1:0] ACC_RST = 3'h0;
    localparam logic [SYM_W-1:0] PREV_RST = 3'h0;

    typedef enum logic [2:0] {
        CODE_PI4_OFF,
        CODE_PI4_NA,
        CODE_PI4_FLIGHT,
        CODE_QPSK_DIFF,
        CODE_8PSK_AVDL
    } coding_t;

    typedef struct packed {
        logic [SYM_W-1:0] sym;
        logic [PH_W-1:0] inc;
        logic [PH_W-1:0] acc;
    } phase_word_t;
endpackage

// [design/sym_fifo.sv]
// Synchronous valid/ready FIFO for input symbols
`timescale 1ns/100ps
module sym_fifo #(
    parameter int W = 3,
    parameter int D = 8
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [W-1:0] in_data, // Word in
    output logic out_valid, // Word available
    input wire logic out_ready, // Drain side accepts
    output logic [W-1:0] out_data // Oldest word
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(D);
    localparam logic [AW-1:0] LAST_IDX = AW'(D - 1);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic in_ready_q;
    logic push;
    logic pop;

    assign push = in_valid && in_ready_q;
    assign pop = out_valid && out_ready;
    assign in_ready = in_ready_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            in_ready_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            // Registered so the upstream ready is glitch free
            in_ready_q <= (cnt_d != FULL_CNT);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// [sim/phase_sink.sv]
// Downstream phase accumulator model with selectable stall pattern
`timescale 1ns/100ps
module phase_sink (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [1:0] stall, // 0 always ready, 1 every other cycle, 2 held off
    input wire logic ph_valid, // Word offered
    output logic ph_ready, // Word taken at this edge
    input wire psk_map_pkg::phase_word_t ph_out, // Offered word
    output logic seen_stb, // One cycle per accepted word
    output psk_map_pkg::phase_word_t seen // Accepted word
);
    logic tog_q;

    // Ready only changes after an edge, never mid-cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            tog_q <= 1'b0;
            ph_ready <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            ph_ready <= (stall == 2'h0) || (stall == 2'h1 && tog_q);
        end
    end

    always_ff @(posedge clk) begin
        seen_stb <= !rst && ph_valid && ph_ready;
        seen <= ph_out;
    end
endmodule

// [sim/testbench.sv]
// Self-checking bench for the differential phase mapper
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    psk_map_pkg::coding_t coding = psk_map_pkg::CODE_PI4_OFF;
    logic sym_valid = 1'b0;
    logic [2:0] sym_data = 3'h0;
    logic [1:0] stall = 2'h0;
    logic sym_ready, ph_valid, ph_ready, seen_stb;
    psk_map_pkg::phase_word_t ph_out, seen;
    psk_map_pkg::phase_word_t got[$];
    logic [2:0] syms[16];
    logic [2:0] e_prev, e_acc;
    int n_in;
    int n_mismatch = 0;
    int num_checks = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) if (seen_stb) got.push_back(seen);

    dpsk_phase_shift_mapper dpsk_phase_shift_mapper_inst (.clk(clk), .rst(rst), .coding(coding),
        .sym_valid(sym_valid), .sym_ready(sym_ready), .sym_data(sym_data), .ph_valid(ph_valid),
        .ph_ready(ph_ready), .ph_out(ph_out));
    phase_sink phase_sink_inst (.clk(clk), .rst(rst), .stall(stall), .ph_valid(ph_valid),
        .ph_ready(ph_ready), .ph_out(ph_out), .seen_stb(seen_stb), .seen(seen));

    task automatic end_sim;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(string what, logic [8:0] exp, logic [8:0] act);
        num_checks++;
        if (exp !== act) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, act);
        end
    endtask

    // Reference model, state cleared whenever coding is applied afresh
    function automatic psk_map_pkg::phase_word_t model(psk_map_pkg::coding_t cd, logic [2:0] a);
        psk_map_pkg::phase_word_t w;
        logic [23:0] t;
        int x;
        x = int'(a[1:0]);
        t = 24'h0;
        case (cd)
            psk_map_pkg::CODE_PI4_OFF: t[11:0] = {psk_map_pkg::PH_315, psk_map_pkg::PH_225,
                psk_map_pkg::PH_135, psk_map_pkg::PH_45};
            psk_map_pkg::CODE_PI4_NA: t[11:0] = {psk_map_pkg::PH_225, psk_map_pkg::PH_315,
                psk_map_pkg::PH_135, psk_map_pkg::PH_45};
            psk_map_pkg::CODE_PI4_FLIGHT: t[11:0] = {psk_map_pkg::PH_45, psk_map_pkg::PH_315,
                psk_map_pkg::PH_135, psk_map_pkg::PH_225};
            psk_map_pkg::CODE_QPSK_DIFF: t[11:0] = {psk_map_pkg::PH_270, psk_map_pkg::PH_180,
                psk_map_pkg::PH_90, psk_map_pkg::PH_0};
            default: begin
                // Gray stage already folded into this table
                t = {psk_map_pkg::PH_180, psk_map_pkg::PH_225, psk_map_pkg::PH_315, psk_map_pkg::PH_270,
                    psk_map_pkg::PH_90, psk_map_pkg::PH_135, psk_map_pkg::PH_45, psk_map_pkg::PH_0};
                x = int'(a);
            end
        endcase
        w.inc = t[3*x +: 3];
        w.sym = {1'b0, a[1:0]};
        if (cd == psk_map_pkg::CODE_QPSK_DIFF) w.sym = {1'b0, a[1:0] + e_prev[1:0]};
        if (cd == psk_map_pkg::CODE_8PSK_AVDL) w.sym = w.inc + e_prev;
        w.acc = e_acc + w.inc;
        e_acc = w.acc;
        e_prev = w.sym;
        return w;
    endfunction

    task automatic push(logic [2:0] d);
        int k;
        k = 0;
        sym_valid <= 1'b1;
        sym_data <= d;
        @(posedge clk);
        while (sym_ready !== 1'b1 && k < 300) begin
            @(posedge clk);
            k++;
        end
        n_in++;
    endtask

    task automatic run_seq(psk_map_pkg::coding_t cd, int n);
        int k;
        coding <= cd;
        repeat (4) @(posedge clk);
        e_prev = psk_map_pkg::PREV_RST;
        e_acc = psk_map_pkg::ACC_RST;
        got.delete();
        n_in = 0;
        for (int i = 0; i < n; i++) push(syms[i]);
        sym_valid <= 1'b0;
        k = 0;
        while (got.size() < n && k < 300) begin
            @(posedge clk);
            k++;
        end
        check("word count", 9'(n), 9'(got.size()));
        for (int i = 0; i < n && i < got.size(); i++) check("ph_out", model(cd, syms[i]), got[i]);
    endtask

    task automatic t_pi4_tables;
        syms = '{0: 3'h0, 1: 3'h1, 2: 3'h2, 3: 3'h3, 4: 3'h7, 5: 3'h6, 6: 3'h1, default: 3'h0};
        run_seq(psk_map_pkg::CODE_PI4_OFF, 8);
        run_seq(psk_map_pkg::CODE_PI4_NA, 8);
        run_seq(psk_map_pkg::CODE_PI4_FLIGHT, 8);
    endtask

    task automatic t_qpsk_diff;
        syms = '{0: 3'h2, 1: 3'h2, 2: 3'h1, 3: 3'h3, 4: 3'h0, 5: 3'h3, 6: 3'h5, 7: 3'h1, default: 3'h0};
        run_seq(psk_map_pkg::CODE_QPSK_DIFF, 8);
    endtask

    task automatic t_avdl;
        for (int i = 0; i < 8; i++) syms[i] = 3'(i);
        syms[8] = 3'h5;
        syms[9] = 3'h5;
        run_seq(psk_map_pkg::CODE_8PSK_AVDL, 10);
    endtask

    // FIFO must fill and refuse while the far side holds off, then drain in order
    task automatic t_backpressure;
        for (int i = 0; i < 12; i++) syms[i] = 3'(11 - i);
        stall <= 2'h2;
        fork
            run_seq(psk_map_pkg::CODE_PI4_NA, 12);
            begin
                repeat (40) @(posedge clk);
                check("refused while full", 9'h0, {8'h0, sym_ready});
                check("filled to depth", 9'h1, {8'h0, n_in >= psk_map_pkg::FIFO_DEPTH});
                stall <= 2'h1;
            end
        join
        stall <= 2'h0;
    endtask

    task automatic t_reset_clear;
        syms = '{0: 3'h1, 1: 3'h3, 2: 3'h2, 3: 3'h1, default: 3'h0};
        run_seq(psk_map_pkg::CODE_QPSK_DIFF, 4);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check("ph_valid in reset", 9'h0, {8'h0, ph_valid});
        check("ph_out in reset", 9'h0, ph_out);
        rst <= 1'b0;
        run_seq(psk_map_pkg::CODE_QPSK_DIFF, 4);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_pi4_tables();
        t_qpsk_diff();
        t_avdl();
        t_backpressure();
        t_reset_clear();
        end_sim();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
endmodule
